//--- hw/bcr_cfg.svh
// constants for the program-flow unit: sizes, state counts, penalties
// assumes one core state per ref_clk cycle
`ifndef BCR_CFG_SVH
`define BCR_CFG_SVH
`define BCR_PC_W 24
`define BCR_PC_RESET 24'h000000
`define BCR_TRAP_VECTOR 24'h00007b
`define BCR_ABS_LSB 11
`define BCR_ST_CARRY 5'h01
`define BCR_ST_FLAG 5'h02
`define BCR_ST_BIT_LONG 5'h04
`define BCR_ST_CLR_BIT 5'h04
`define BCR_ST_CLR_BIT_LONG 5'h07
`define BCR_ST_CMP_IND 5'h03
`define BCR_ST_COUNT_DOWN_LOOP_BRANCH 5'h03
`define BCR_ST_TAKEN_ADD 5'h03
`define BCR_ST_ABSOLUTE_PAGE_JUMP 5'h03
`define BCR_ST_EXTENDED_JUMP 5'h06
`define BCR_ST_LONG_JUMP 5'h07
`define BCR_ST_ABSOLUTE_PAGE_CALL 5'h09
`define BCR_ST_EXTENDED_CALL 5'h0e
`define BCR_ST_LONG_CALL 5'h0a
`define BCR_ST_RET 5'h07
`define BCR_ST_SUBROUTINE_EXIT_EXTENDED 5'h09
`define BCR_ST_TRAP 5'h0c
`define BCR_ST_FRAME24 5'h05
`define BCR_ST_EXT_ABS 5'h02
`define BCR_ST_EXT 5'h03
`endif

//--- hw/bcr_pkg.sv
// types for the program-flow unit
// shared by the flow unit and its bench
package bcr_pkg;
    typedef enum logic [4:0] {
        BRANCH_ON_CARRY_SET, BRANCH_ON_CARRY_CLEAR, BRANCH_ON_EQUAL,
        BRANCH_ON_UNEQUAL, BRANCH_ON_ABOVE, BRANCH_ON_BELOW_OR_SAME,
        BRANCH_SIGNED_LESS, BRANCH_SIGNED_LESS_OR_SAME, BRANCH_SIGNED_GREATER,
        BRANCH_SIGNED_GREATER_OR_SAME, BRANCH_ON_BIT_SET, BRANCH_ON_BIT_CLEAR,
        BRANCH_AND_CLEAR_BIT, BRANCH_ON_ACC_ZERO, BRANCH_ON_ACC_NONZERO,
        COMPARE_BRANCH_UNEQUAL, COUNT_DOWN_LOOP_BRANCH, ABSOLUTE_PAGE_JUMP,
        EXTENDED_JUMP, LONG_JUMP, ABSOLUTE_PAGE_CALL, EXTENDED_CALL, LONG_CALL,
        SUBROUTINE_EXIT_SHORT, SUBROUTINE_EXIT_EXTENDED, INTERRUPT_EXIT, SOFT_TRAP
    } bcr_op_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_STACK = 3'b010,
        ST_COUNT = 3'b100
    } bcr_state_t;
endpackage

//--- hw/bcr_flow_unit.sv
// program-flow unit: conditional jumps, jumps, calls, returns and trap
// assumes stack memory answers a pop with data in the same cycle
`timescale 1ns/1ns
`default_nettype none
`include "bcr_cfg.svh"
module bcr_flow_unit (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic start,
    input wire bcr_pkg::bcr_op_t op,
    input wire logic long_form,
    input wire logic opnd_indirect,
    input wire logic opnd_direct,
    input wire logic opnd_port,
    input wire logic opnd_sfr,
    input wire logic flag_cy,
    input wire logic flag_z,
    input wire logic flag_n,
    input wire logic flag_ov,
    input wire logic opnd_bit,
    input wire logic [7:0] acc,
    input wire logic [7:0] cmp_a,
    input wire logic [7:0] cmp_b,
    input wire logic [7:0] dec_opnd,
    input wire logic [7:0] rel,
    input wire logic [23:0] addr_opnd,
    input wire logic [23:0] pc_in,
    input wire logic internal_exec,
    input wire logic dest_external,
    input wire logic interrupt_frame_mode_bit,
    input wire logic [7:0] second_status_word,
    input wire logic [7:0] stack_rdata,
    output logic busy,
    output logic done,
    output logic [23:0] pc_r,
    output logic taken_r,
    output logic [4:0] states_r,
    output logic bit_clear_r,
    output logic [7:0] dec_result_r,
    output logic psw_load_r,
    output logic [7:0] psw_out_r,
    output logic stack_push,
    output logic [7:0] stack_wdata,
    output logic stack_pop
);
    // ==========================================================
    // reset release
    logic rst_s1_r, rst_n_r;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // ==========================================================
    // instruction classes
    bcr_pkg::bcr_state_t st_r, st_nxt;
    wire is_cond = (op <= bcr_pkg::COUNT_DOWN_LOOP_BRANCH);
    wire is_abs = (op == bcr_pkg::ABSOLUTE_PAGE_JUMP) || (op == bcr_pkg::ABSOLUTE_PAGE_CALL);
    wire is_call = (op == bcr_pkg::ABSOLUTE_PAGE_CALL) || (op == bcr_pkg::EXTENDED_CALL)
        || (op == bcr_pkg::LONG_CALL);
    wire is_trap = (op == bcr_pkg::SOFT_TRAP);
    wire is_ret = (op == bcr_pkg::SUBROUTINE_EXIT_SHORT) || (op == bcr_pkg::INTERRUPT_EXIT)
        || (op == bcr_pkg::SUBROUTINE_EXIT_EXTENDED);
    wire is_uncond = !is_cond && !is_ret;
    wire frame24 = interrupt_frame_mode_bit;
    wire is_bit = (op == bcr_pkg::BRANCH_ON_BIT_SET) || (op == bcr_pkg::BRANCH_ON_BIT_CLEAR);
    wire is_clr = (op == bcr_pkg::BRANCH_AND_CLEAR_BIT);
    wire is_carry = (op <= bcr_pkg::BRANCH_ON_CARRY_CLEAR);

    // ==========================================================
    // condition evaluation
    wire slt = flag_n ^ flag_ov;
    wire [7:0] dec_val = dec_opnd - 8'h01;
    logic cond;
    always_comb begin
        case (op)
            bcr_pkg::BRANCH_ON_CARRY_SET: cond = flag_cy;
            bcr_pkg::BRANCH_ON_CARRY_CLEAR: cond = !flag_cy;
            bcr_pkg::BRANCH_ON_EQUAL: cond = flag_z;
            bcr_pkg::BRANCH_ON_UNEQUAL: cond = !flag_z;
            bcr_pkg::BRANCH_ON_ABOVE: cond = !flag_cy && !flag_z;
            bcr_pkg::BRANCH_ON_BELOW_OR_SAME: cond = flag_cy || flag_z;
            bcr_pkg::BRANCH_SIGNED_LESS: cond = slt;
            bcr_pkg::BRANCH_SIGNED_LESS_OR_SAME: cond = slt || flag_z;
            bcr_pkg::BRANCH_SIGNED_GREATER: cond = !slt && !flag_z;
            bcr_pkg::BRANCH_SIGNED_GREATER_OR_SAME: cond = !slt;
            bcr_pkg::BRANCH_ON_BIT_SET: cond = opnd_bit;
            bcr_pkg::BRANCH_ON_BIT_CLEAR: cond = !opnd_bit;
            bcr_pkg::BRANCH_AND_CLEAR_BIT: cond = opnd_bit;
            bcr_pkg::BRANCH_ON_ACC_ZERO: cond = (acc == 8'h00);
            bcr_pkg::BRANCH_ON_ACC_NONZERO: cond = (acc != 8'h00);
            bcr_pkg::COMPARE_BRANCH_UNEQUAL: cond = (cmp_a != cmp_b);
            bcr_pkg::COUNT_DOWN_LOOP_BRANCH: cond = (dec_val != 8'h00);
            default: cond = 1'b1;
        endcase
    end
    wire taken = cond && !is_ret;

    // ==========================================================
    // instruction length and next address
    logic [2:0] size;
    always_comb begin
        if (is_carry || op == bcr_pkg::BRANCH_ON_ACC_ZERO || op == bcr_pkg::BRANCH_ON_ACC_NONZERO
            || is_abs || is_trap) begin
            size = 3'h2;
        end else if ((is_bit || is_clr) && long_form) begin
            size = 3'h5;
        end else if (op == bcr_pkg::COUNT_DOWN_LOOP_BRANCH) begin
            size = opnd_direct ? 3'h3 : 3'h2;
        end else if (op == bcr_pkg::EXTENDED_JUMP) begin
            size = 3'h5;
        end else if (op == bcr_pkg::SUBROUTINE_EXIT_SHORT || op == bcr_pkg::INTERRUPT_EXIT) begin
            size = 3'h1;
        end else begin
            size = 3'h3;
        end
    end
    // step past the whole instruction first
    wire [23:0] seq_pc = pc_in + {21'h000000, size};
    wire [23:0] rel_pc = seq_pc + {{16{rel[7]}}, rel};
    logic [23:0] target;
    always_comb begin
        if (is_cond) begin
            target = taken ? rel_pc : seq_pc;
        end else if (is_abs) begin
            // upper bits kept from next address
            target = {seq_pc[23:`BCR_ABS_LSB], addr_opnd[`BCR_ABS_LSB-1:0]};
        end else if (op == bcr_pkg::EXTENDED_JUMP || op == bcr_pkg::EXTENDED_CALL) begin
            target = addr_opnd;
        end else if (op == bcr_pkg::LONG_JUMP || op == bcr_pkg::LONG_CALL) begin
            target = {seq_pc[23:16], addr_opnd[15:0]};
        end else if (is_trap) begin
            target = `BCR_TRAP_VECTOR;
        end else begin
            target = seq_pc;
        end
    end

    // ==========================================================
    // state counts
    logic [4:0] base, port_add;
    always_comb begin
        case (op)
            bcr_pkg::BRANCH_ON_CARRY_SET, bcr_pkg::BRANCH_ON_CARRY_CLEAR: base = `BCR_ST_CARRY;
            bcr_pkg::BRANCH_ON_BIT_SET, bcr_pkg::BRANCH_ON_BIT_CLEAR:
                base = long_form ? `BCR_ST_BIT_LONG : `BCR_ST_FLAG;
            bcr_pkg::BRANCH_AND_CLEAR_BIT:
                base = long_form ? `BCR_ST_CLR_BIT_LONG : `BCR_ST_CLR_BIT;
            bcr_pkg::COMPARE_BRANCH_UNEQUAL: base = opnd_indirect ? `BCR_ST_CMP_IND : `BCR_ST_FLAG;
            bcr_pkg::COUNT_DOWN_LOOP_BRANCH: base = `BCR_ST_COUNT_DOWN_LOOP_BRANCH;
            bcr_pkg::ABSOLUTE_PAGE_JUMP: base = `BCR_ST_ABSOLUTE_PAGE_JUMP;
            bcr_pkg::EXTENDED_JUMP: base = `BCR_ST_EXTENDED_JUMP;
            bcr_pkg::LONG_JUMP: base = `BCR_ST_LONG_JUMP;
            bcr_pkg::ABSOLUTE_PAGE_CALL: base = `BCR_ST_ABSOLUTE_PAGE_CALL;
            bcr_pkg::EXTENDED_CALL: base = `BCR_ST_EXTENDED_CALL;
            bcr_pkg::LONG_CALL: base = `BCR_ST_LONG_CALL;
            bcr_pkg::SUBROUTINE_EXIT_SHORT: base = `BCR_ST_RET;
            bcr_pkg::SUBROUTINE_EXIT_EXTENDED: base = `BCR_ST_SUBROUTINE_EXIT_EXTENDED;
            bcr_pkg::INTERRUPT_EXIT: base = frame24 ? `BCR_ST_RET + `BCR_ST_FRAME24 : `BCR_ST_RET;
            bcr_pkg::SOFT_TRAP: base = `BCR_ST_TRAP;
            default: base = `BCR_ST_FLAG;
        endcase
        // port 1/2/3, peripheral register 2/3/5 by instruction class
        if (!is_cond || !(opnd_port || opnd_sfr)) begin
            port_add = 5'h00;
        end else if (is_clr) begin
            port_add = opnd_port ? 5'h03 : 5'h05;
        end else if ((is_bit && long_form) || op == bcr_pkg::COUNT_DOWN_LOOP_BRANCH) begin
            port_add = opnd_port ? 5'h02 : 5'h03;
        end else begin
            port_add = opnd_port ? 5'h01 : 5'h02;
        end
    end
    // taken path three states longer, four with an odd internal target
    wire [4:0] taken_add = (is_cond && taken) ? `BCR_ST_TAKEN_ADD : 5'h00;
    wire [4:0] ext_add = !(is_uncond && dest_external) ? 5'h00
        : (is_abs ? `BCR_ST_EXT_ABS : `BCR_ST_EXT);
    // odd internal target; the trap has no such penalty
    wire odd_pen = internal_exec && !dest_external && target[0] && !is_trap
        && (is_uncond || taken);
    wire [4:0] total = base + port_add + taken_add + ext_add + {4'h0, odd_pen};

    // ==========================================================
    // stack operations: pushes go low byte first, pops return high byte first
    // push and pop byte counts
    wire [2:0] n_push = (op == bcr_pkg::EXTENDED_CALL) ? 3'h3
        : (is_trap && frame24) ? 3'h4 : (is_call || is_trap) ? 3'h2 : 3'h0;
    wire [2:0] n_pop = (op == bcr_pkg::SUBROUTINE_EXIT_EXTENDED) ? 3'h3
        : (op == bcr_pkg::INTERRUPT_EXIT && frame24) ? 3'h4 : is_ret ? 3'h2 : 3'h0;
    // status word goes first, ahead of the 24-bit return address
    wire [31:0] push_init = (is_trap && frame24) ? {seq_pc, second_status_word} : {8'h00, seq_pc};

    logic [2:0] ops_r;
    logic pop_mode_r, frame_r, odd_ok_r, short_ret_r;
    logic [31:0] push_sh_r;
    logic [23:0] pop_sh_r;
    logic [4:0] rem_r;
    wire start_ok = start && (st_r == bcr_pkg::ST_IDLE);
    wire in_stack = (st_r == bcr_pkg::ST_STACK);
    wire last_op = in_stack && (ops_r == 3'h1);
    wire [31:0] pop_cat = {pop_sh_r, stack_rdata};
    // short forms restore 16 bits only; extended ones all 24
    wire [23:0] ret_pc = short_ret_r ? {pc_r[23:16], pop_cat[15:0]}
        : (frame_r ? pop_cat[31:8] : pop_cat[23:0]);
    wire ret_odd = odd_ok_r && ret_pc[0];

    assign busy = (st_r != bcr_pkg::ST_IDLE);
    assign stack_push = in_stack && !pop_mode_r;
    assign stack_pop = in_stack && pop_mode_r;
    assign stack_wdata = push_sh_r[7:0];
    assign done = (st_r == bcr_pkg::ST_COUNT) && (rem_r == 5'h00);

    // sequencer
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            bcr_pkg::ST_IDLE: if (start) st_nxt = (n_push != 3'h0 || n_pop != 3'h0)
                ? bcr_pkg::ST_STACK : bcr_pkg::ST_COUNT;
            bcr_pkg::ST_STACK: if (ops_r == 3'h1) st_nxt = bcr_pkg::ST_COUNT;
            bcr_pkg::ST_COUNT: if (rem_r == 5'h00) st_nxt = bcr_pkg::ST_IDLE;
            default: st_nxt = bcr_pkg::ST_IDLE;
        endcase
    end

    // remaining states; a popped odd target only becomes known at the last pop
    wire [4:0] rem_nxt = start_ok ? total - 5'h01
        : (rem_r - {4'h0, busy && rem_r != 5'h00} + {4'h0, last_op && pop_mode_r && ret_odd});

    always_ff @(posedge ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r <= bcr_pkg::ST_IDLE;
            rem_r <= 5'h00;
            ops_r <= 3'h0;
        end else begin
            st_r <= st_nxt;
            rem_r <= rem_nxt;
            ops_r <= start_ok ? n_push | n_pop : ops_r - {2'h0, in_stack};
        end
    end

    // latched results of the instruction
    always_ff @(posedge ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pc_r <= `BCR_PC_RESET;
            taken_r <= 1'b0;
            states_r <= 5'h00;
            dec_result_r <= 8'h00;
            pop_mode_r <= 1'b0;
            frame_r <= 1'b0;
            odd_ok_r <= 1'b0;
            short_ret_r <= 1'b0;
        end else if (start_ok) begin
            pc_r <= target;
            taken_r <= taken;
            states_r <= total;
            dec_result_r <= (op == bcr_pkg::COUNT_DOWN_LOOP_BRANCH) ? dec_val : dec_result_r;
            pop_mode_r <= is_ret;
            frame_r <= frame24 && (op == bcr_pkg::INTERRUPT_EXIT);
            odd_ok_r <= internal_exec && !dest_external;
            short_ret_r <= (op == bcr_pkg::SUBROUTINE_EXIT_SHORT)
                || (op == bcr_pkg::INTERRUPT_EXIT && !frame24);
        end else if (last_op && pop_mode_r) begin
            // return address restored after the final pop
            pc_r <= ret_pc;
            taken_r <= 1'b1;
            states_r <= states_r + {4'h0, ret_odd};
        end
    end

    // shift registers and one-cycle strobes
    always_ff @(posedge ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            push_sh_r <= 32'h00000000;
            pop_sh_r <= 24'h000000;
            bit_clear_r <= 1'b0;
            psw_load_r <= 1'b0;
            psw_out_r <= 8'h00;
        end else begin
            push_sh_r <= start_ok ? push_init : (stack_push ? push_sh_r >> 8 : push_sh_r);
            pop_sh_r <= start_ok ? 24'h000000 : (stack_pop ? pop_cat[23:0] : pop_sh_r);
            // addressed bit cleared when the jump is taken
            bit_clear_r <= start_ok && is_clr && opnd_bit;
            psw_load_r <= last_op && pop_mode_r && frame_r;
            psw_out_r <= (last_op && pop_mode_r && frame_r) ? pop_cat[7:0] : psw_out_r;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n_r);
    logic [4:0] busy_cnt_r;
    always_ff @(posedge ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) busy_cnt_r <= 5'h00;
        else busy_cnt_r <= busy ? busy_cnt_r + 5'h01 : 5'h00;
    end
    wire [23:0] seq_hi = seq_pc;
    state_count_a: assert property (done |-> busy_cnt_r == states_r - 5'h01)
        else $error("busy length differs from state count");
    carry_nt_a: assert property (start_ok && op == bcr_pkg::BRANCH_ON_CARRY_SET && !flag_cy
        && !opnd_port && !opnd_sfr |=> states_r == 5'h01 && pc_r == $past(seq_hi))
        else $error("carry jump not taken wrong");
    above_a: assert property (start_ok && op == bcr_pkg::BRANCH_ON_ABOVE
        |=> taken_r == ($past(!flag_cy) && $past(!flag_z)))
        else $error("unsigned above wrong");
    signed_lt_a: assert property (start_ok && op == bcr_pkg::BRANCH_SIGNED_LESS
        |=> taken_r == ($past(flag_n) != $past(flag_ov)))
        else $error("signed less wrong");
    clear_bit_a: assert property (start_ok && is_clr && opnd_bit |=> bit_clear_r ##1 !bit_clear_r)
        else $error("bit clear strobe missing");
    abs_upper_a: assert property (start_ok && op == bcr_pkg::ABSOLUTE_PAGE_JUMP
        |=> pc_r[23:11] == $past(seq_hi[23:11]) && busy && busy_cnt_r == 5'h00)
        else $error("absolute jump upper bits changed");
    extended_call_push_a: assert property (start_ok && op == bcr_pkg::EXTENDED_CALL
        |=> stack_push [*3] ##1 !stack_push)
        else $error("extended call push count wrong");
    ret_pop_a: assert property (start_ok && op == bcr_pkg::SUBROUTINE_EXIT_SHORT
        |=> stack_pop [*2] ##1 !stack_pop)
        else $error("short return pop count wrong");
    trap_frame_a: assert property (start_ok && is_trap && frame24
        |=> stack_push && stack_wdata == $past(second_status_word) ##1 stack_push [*3])
        else $error("trap frame push wrong");
    done_within_a: assert property (start_ok |-> ##[1:20] done)
        else $error("instruction never completed");
    cover_taken_c: cover property (start_ok && is_cond && taken ##[1:20] done);
    cover_call_c: cover property (start_ok && is_call ##[1:20] done);
    cover_interrupt_exit_c: cover property (psw_load_r);
endmodule // bcr_flow_unit
`default_nettype wire

//--- tb/bcr_stack_model.sv
// stack memory partner for the program-flow unit
// assumes one pushed or popped byte per ref_clk cycle
`timescale 1ns/1ns
`default_nettype none
// ==========
// byte stack
module bcr_stack_model (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic stack_push,
    input wire logic [7:0] stack_wdata,
    input wire logic stack_pop,
    output logic [7:0] stack_rdata
);
    logic [7:0] mem_r [0:31];
    logic [4:0] sp_r;
    logic [7:0] last_r;
    // last in, first out; a pop is answered in its own cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sp_r <= 5'h00;
            last_r <= 8'h00;
        end else if (stack_push) begin
            mem_r[sp_r] <= stack_wdata;
            sp_r <= sp_r + 5'h01;
        end else if (stack_pop) begin
            last_r <= stack_rdata;
            sp_r <= sp_r - 5'h01;
        end
    end
    // outside a pop the line shows the inverse of the last byte, so stale data never matches
    assign stack_rdata = stack_pop ? mem_r[sp_r - 5'h01] : ~last_r;
endmodule // bcr_stack_model
`default_nettype wire

//--- tb/tb_bcr_flow_unit.sv
// self-checking bench for the program-flow unit
// assumes the stack partner model and one state per ref_clk cycle
`timescale 1ns/1ns
`default_nettype none
`include "bcr_cfg.svh"
// ==========
// bench top
module tb_bcr_flow_unit;
    typedef struct {
        logic [4:0] op;
        logic [4:0] fl;
        logic [7:0] val;
        logic [6:0] md;
        logic [23:0] adr;
        logic [23:0] epc;
        logic [4:0] est;
        logic [2:0] sb;
        logic tk;
    } bcr_row_t;
    logic ref_clk, reset_n, start, long_form, opnd_indirect, opnd_direct, opnd_port, opnd_sfr;
    logic flag_cy, flag_z, flag_n, flag_ov, opnd_bit, internal_exec, dest_external;
    logic interrupt_frame_mode_bit, busy, done, taken_r, bit_clear_r, psw_load_r;
    logic stack_push, stack_pop;
    logic [7:0] acc, cmp_a, cmp_b, dec_opnd, rel, second_status_word, stack_rdata;
    logic [7:0] dec_result_r, psw_out_r, stack_wdata;
    logic [23:0] addr_opnd, pc_in, pc_r;
    logic [4:0] states_r;
    bcr_pkg::bcr_op_t op;
    int fail_count = 0;
    int n_compared = 0;
    int n_clr;
    int n_psw;
    bcr_row_t rows[30];
    bcr_flow_unit u_bcr_flow_unit (.ref_clk, .reset_n, .start, .op, .long_form, .opnd_indirect,
        .opnd_direct, .opnd_port, .opnd_sfr, .flag_cy, .flag_z, .flag_n, .flag_ov, .opnd_bit,
        .acc, .cmp_a, .cmp_b, .dec_opnd, .rel, .addr_opnd, .pc_in, .internal_exec,
        .dest_external, .interrupt_frame_mode_bit, .second_status_word, .stack_rdata, .busy,
        .done, .pc_r, .taken_r, .states_r, .bit_clear_r, .dec_result_r, .psw_load_r,
        .psw_out_r, .stack_push, .stack_wdata, .stack_pop);
    bcr_stack_model u_bcr_stack_model (.ref_clk, .reset_n, .stack_push, .stack_wdata,
        .stack_pop, .stack_rdata);
    // 25 MHz core clock
    always #20 ref_clk = ~ref_clk;
    // ==========
    // compares
    task automatic chk_pc(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_n(input string nm, input logic [7:0] e, input logic [7:0] g);
        chk_pc(nm, {16'h0000, e}, {16'h0000, g});
    endtask
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one instruction: inputs at a falling edge, then count cycles until done
    task automatic run_op(input bcr_row_t r, input logic hold);
        int nb;
        int ns;
        @(negedge ref_clk);
        op = bcr_pkg::bcr_op_t'(r.op);
        {opnd_bit, flag_ov, flag_n, flag_z, flag_cy} = r.fl;
        {opnd_indirect, opnd_sfr, opnd_port, interrupt_frame_mode_bit} = r.md[6:3];
        {dest_external, internal_exec, long_form} = r.md[2:0];
        {acc, cmp_a, dec_opnd} = {3{r.val}};
        addr_opnd = r.adr;
        start = 1'b1;
        nb = 0;
        ns = 0;
        n_clr = 0;
        n_psw = 0;
        for (int k = 0; k < 40; k++) begin
            @(negedge ref_clk);
            start = hold;
            if (busy === 1'b1) nb++;
            if (stack_push === 1'b1 || stack_pop === 1'b1) ns++;
            if (bit_clear_r === 1'b1) n_clr++;
            if (psw_load_r === 1'b1) n_psw++;
            if (done === 1'b1) break;
        end
        start = 1'b0;
        chk_pc("pc", r.epc, pc_r);
        chk_n("states", {3'h0, r.est}, {3'h0, states_r});
        chk_n("busy", {3'h0, r.est}, 8'(nb));
        chk_n("stack", {5'h00, r.sb}, 8'(ns));
        if (r.op < 5'd17) chk_n("taken", {7'h00, r.tk}, {7'h00, taken_r});
        $display("test op %0d done", r.op);
    endtask
    // hang guard, well beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge ref_clk);
        fail_count++;
        finish_test();
    end
    // ==========
    // main sequence
    initial begin
        rows = '{'{0, 1, 0, 0, 0, 'h3a1242, 4, 0, 1}, '{1, 1, 0, 0, 0, 'h3a1232, 1, 0, 0},
            '{2, 2, 0, 0, 0, 'h3a1243, 5, 0, 1}, '{3, 2, 0, 0, 0, 'h3a1233, 2, 0, 0},
            '{4, 0, 0, 0, 0, 'h3a1243, 5, 0, 1}, '{5, 0, 0, 0, 0, 'h3a1233, 2, 0, 0},
            '{6, 4, 0, 0, 0, 'h3a1243, 5, 0, 1}, '{7, 0, 0, 0, 0, 'h3a1233, 2, 0, 0},
            '{8, 0, 0, 0, 0, 'h3a1243, 5, 0, 1}, '{9, 4, 0, 0, 0, 'h3a1233, 2, 0, 0},
            '{10, 'h10, 0, 0, 0, 'h3a1243, 5, 0, 1}, '{11, 'h10, 0, 0, 0, 'h3a1233, 2, 0, 0},
            '{11, 0, 0, 1, 0, 'h3a1245, 7, 0, 1}, '{12, 'h10, 0, 0, 0, 'h3a1243, 7, 0, 1},
            '{13, 0, 0, 0, 0, 'h3a1242, 5, 0, 1}, '{14, 0, 0, 0, 0, 'h3a1232, 2, 0, 0},
            '{15, 0, 5, 0, 0, 'h3a1233, 2, 0, 0}, '{15, 0, 0, 'h40, 0, 'h3a1243, 6, 0, 1},
            '{16, 0, 0, 0, 0, 'h3a1242, 6, 0, 1}, '{17, 0, 0, 0, 'h5505a4, 'h3a15a4, 3, 0, 1},
            '{18, 0, 0, 0, 'habcdee, 'habcdee, 6, 0, 1}, '{19, 0, 0, 0, 'h55beee, 'h3abeee, 7, 0, 1},
            '{20, 0, 0, 0, 'h5505a4, 'h3a15a4, 9, 2, 1}, '{23, 0, 0, 0, 0, 'h3a1232, 7, 2, 1},
            '{21, 0, 0, 0, 'habcdee, 'habcdee, 14, 3, 1}, '{24, 0, 0, 0, 0, 'h3a1233, 9, 3, 1},
            '{22, 0, 0, 0, 'h55beee, 'h3abeee, 10, 2, 1}, '{25, 0, 0, 0, 0, 'h3a1233, 7, 2, 1},
            '{26, 0, 0, 0, 0, `BCR_TRAP_VECTOR, 12, 2, 1}, '{25, 0, 0, 0, 0, 'h3a1232, 7, 2, 1}};
        ref_clk = 1'b0;
        reset_n = 1'b0;
        op = bcr_pkg::BRANCH_ON_CARRY_SET;
        {start, long_form, opnd_indirect, opnd_direct, opnd_port, opnd_sfr, flag_cy} = 7'h00;
        {flag_z, flag_n, flag_ov, opnd_bit, internal_exec, dest_external} = 6'h00;
        {interrupt_frame_mode_bit, acc, cmp_a, dec_opnd, addr_opnd} = 49'h0;
        {pc_in, rel, cmp_b, second_status_word} = 48'h3a1230_10_05_c6;
        repeat (16) @(negedge ref_clk);
        chk_pc("reset pc", 24'h000000, pc_r);
        chk_n("reset busy", 8'h00, {busy, done, stack_push, stack_pop, 4'h0});
        reset_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        foreach (rows[i]) run_op(rows[i], 1'b0);
        // awkward cases: backward offset, odd and external targets, port and status penalties
        run_op('{0, 0, 0, 0, 0, 'h3a1232, 1, 0, 0}, 1'b0);
        opnd_direct = 1'b1;
        run_op('{16, 0, 2, 0, 0, 'h3a1243, 6, 0, 1}, 1'b0);
        chk_n("decrement", 8'h01, dec_result_r);
        opnd_direct = 1'b0;
        rel = 8'hf0;
        run_op('{0, 1, 0, 0, 0, 'h3a1222, 4, 0, 1}, 1'b0);
        rel = 8'h11;
        run_op('{0, 1, 0, 2, 0, 'h3a1243, 5, 0, 1}, 1'b0);
        rel = 8'h10;
        run_op('{19, 0, 0, 2, 'h00beef, 'h3abeef, 8, 0, 1}, 1'b0);
        run_op('{17, 0, 0, 4, 'h0005a4, 'h3a15a4, 5, 0, 1}, 1'b0);
        run_op('{22, 0, 0, 4, 'h55beee, 'h3abeee, 13, 2, 1}, 1'b1);
        run_op('{23, 0, 0, 2, 0, 'h3a1233, 8, 2, 1}, 1'b0);
        run_op('{10, 0, 0, 'h10, 0, 'h3a1233, 3, 0, 0}, 1'b0);
        run_op('{12, 'h10, 0, 'h20, 0, 'h3a1243, 12, 0, 1}, 1'b0);
        chk_n("bit clear", 8'h01, 8'(n_clr));
        run_op('{16, 0, 1, 'h10, 0, 'h3a1232, 5, 0, 0}, 1'b0);
        chk_n("decrement", 8'h00, dec_result_r);
        run_op('{26, 0, 0, 8, 0, `BCR_TRAP_VECTOR, 12, 4, 1}, 1'b0);
        run_op('{25, 0, 0, 8, 0, 'h3a1232, 12, 4, 1}, 1'b0);
        chk_n("status load", 8'h01, 8'(n_psw));
        chk_n("status word", 8'hc6, psw_out_r);
        finish_test();
    end
endmodule // tb_bcr_flow_unit
`default_nettype wire
